// [block_ram.sv]
// Configurable dual-port block memory with queue controller and SEC-DED
`include "bram_map.svh"

module block_ram
	import bram_pkg::*;
#(
	parameter logic PORT_A_USED = 1'b1,
	parameter logic PORT_B_USED = 1'b1
) (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	// Configuration and queue thresholds
	input  wire mem_cfg_t               cfg,
	input  wire fifo_thr_t              thr,
	// Port requests
	input  wire port_req_t              reqA,
	input  wire port_req_t              reqB,
	// Port read data and held addresses
	output logic      [`WORD_BITS-1:0]  doutA,
	output logic      [`WORD_BITS-1:0]  doutB,
	output logic      [`ADDR_W-1:0]     heldAddrA,
	output logic      [`ADDR_W-1:0]     heldAddrB,
	// Cascade path
	input  wire logic [`WORD_BITS-1:0]  casIn,
	output logic      [`WORD_BITS-1:0]  casOut,
	// Error correction status
	output logic                        sbitErr,
	output logic                        dbitErr,
	// Standalone codec
	input  wire logic [`DATA_BITS-1:0]  extEncData,
	output logic      [`CHK_BITS-1:0]   extEncCheck,
	input  wire logic [`WORD_BITS-1:0]  extDecWord,
	output logic      [`DATA_BITS-1:0]  extDecData,
	output logic                        extSbitErr,
	output logic                        extDbitErr,
	// Queue flags and status
	output fifo_flags_t                 flags,
	output logic                        cfgError,
	output logic                        poweredDown
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [`WORDS-1:0][`WORD_BITS-1:0] mem;
		logic [1:0][`WORD_BITS-1:0]        stage;
		logic [1:0][`WORD_BITS-1:0]        dout;
		logic [1:0][`ADDR_W-1:0]           held;
		logic                              sbit;
		logic                              dbit;
		logic [`CHK_BITS-1:0]              xChk;
		logic [`DATA_BITS-1:0]             xData;
		logic                              xS;
		logic                              xD;
		logic [`PTR_W-1:0]                 wrPtr;
		logic [`PTR_W-1:0]                 rdPtr;
		fifo_flags_t                       flags;
		logic                              cfgErr;
		logic                              down;
	} st_t;

	st_t                          st;
	st_t                          next_st;
	logic [1:0]                   goP;
	logic [1:0]                   weP;
	logic [1:0]                   rdP;
	logic [1:0][`WORD_BITS-1:0]   laneP;
	logic [`UNIT_W-1:0]           unitB;
	logic [`WORD_BITS-1:0]        eccRdWord;
	logic [`CHK_BITS-1:0]         eccChk;
	logic [`DATA_BITS-1:0]        eccData;
	logic                         eccS;
	logic                         eccD;
	logic [`CHK_BITS-1:0]         xChk;
	logic [`DATA_BITS-1:0]        xData;
	logic                         xS;
	logic                         xD;

	// ****************************************
	// Lane helpers
	// ****************************************
	function automatic logic [`WIDX_W-1:0] wordIdx(input logic [`UNIT_W-1:0] u,
		input logic half, input logic sel);
		return half ? {sel, u[`UNIT_W-2:`OFF_W]} : u[`UNIT_W-1:`OFF_W];
	endfunction

	function automatic logic [`PTR_W-1:0] unitsOf(input shape_t s);
		return 16'h0001 << s;
	endfunction

	// Narrow shapes use data bits only; nine-bit shapes add one parity bit per byte
	function automatic logic [`WORD_BITS-1:0] getLane(input logic [`WORD_BITS-1:0] w,
		input shape_t s, input logic [`OFF_W-1:0] o);
		logic [`WORD_BITS-1:0] r;
		int u;
		r = '0;
		u = 1 << s;
		for (int i = 0; i < `DATA_BITS; i++) begin
			if (i >= o && i < o + u) r[i - o] = w[i];
		end
		if (s >= SH_X9) begin
			for (int j = 0; j < `CHK_BITS; j++) begin
				if (8 * j >= o && 8 * j < o + u) r[u + j - o / 8] = w[`DATA_BITS + j];
			end
		end
		return r;
	endfunction

	// Returns write mask above write value
	function automatic logic [2*`WORD_BITS-1:0] putLane(input logic [`WORD_BITS-1:0] d,
		input shape_t s, input logic [`OFF_W-1:0] o);
		logic [`WORD_BITS-1:0] m;
		logic [`WORD_BITS-1:0] v;
		int u;
		m = '0;
		v = '0;
		u = 1 << s;
		for (int i = 0; i < `DATA_BITS; i++) begin
			if (i >= o && i < o + u) begin
				m[i] = 1'b1;
				v[i] = d[i - o];
			end
		end
		if (s >= SH_X9) begin
			for (int j = 0; j < `CHK_BITS; j++) begin
				if (8 * j >= o && 8 * j < o + u) begin
					m[`DATA_BITS + j] = 1'b1;
					v[`DATA_BITS + j] = d[u + j - o / 8];
				end
			end
		end
		return {m, v};
	endfunction

	function automatic logic legal(input shape_t s, input logic half, input logic rw);
		if (half) return s <= SH_X18 || (rw && s == SH_X36);
		return s <= SH_X36 || (rw && s == SH_X72);
	endfunction

	// ****************************************
	// Error correction path
	// ****************************************
	// Port B is the only reader of wide protected words, so its word is decoded here
	assign unitB = cfg.fifoMode ? st.rdPtr[`UNIT_W-1:0]
		: `UNIT_W'(reqB.addr[`UNIT_W-1:0] << cfg.shapeB);
	assign eccRdWord = st.mem[wordIdx(unitB, cfg.halfMode, cfg.halfSelB)];

	secded_codec memCodec (
		.encData (reqA.din[`DATA_BITS-1:0]),
		.encCheck(eccChk),
		.decWord (eccRdWord),
		.decData (eccData),
		.sbitErr (eccS),
		.dbitErr (eccD)
	);

	secded_codec extCodec (
		.encData (extEncData),
		.encCheck(xChk),
		.decWord (extDecWord),
		.decData (xData),
		.sbitErr (xS),
		.dbitErr (xD)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		port_req_t               rq [2];
		shape_t                  sh [2];
		logic [1:0]              sel;
		logic [`UNIT_W-1:0]      unit;
		logic [`WIDX_W-1:0]      wi;
		logic [`OFF_W-1:0]       off;
		logic [2*`WORD_BITS-1:0] put;
		logic [`PTR_W-1:0]       cnt;
		logic [`PTR_W-1:0]       cap;
		logic                    act;
		logic                    cas;
		rq[0] = reqA;
		rq[1] = reqB;
		sh[0] = cfg.shapeA;
		sh[1] = cfg.shapeB;
		sel   = {cfg.halfSelB, cfg.halfSelA};
		unit  = '0;
		wi    = '0;
		off   = '0;
		put   = '0;
		cnt   = '0;
		cap   = '0;
		cas   = 1'b0;
		goP   = '0;
		weP   = '0;
		rdP   = '0;
		laneP = '0;
		next_st = st;
		next_st.xChk  = xChk;
		next_st.xData = xData;
		next_st.xS    = xS;
		next_st.xD    = xD;
		next_st.down  = cfg.sleep || !(PORT_A_USED || PORT_B_USED);
		next_st.cfgErr = !(legal(sh[0], cfg.halfMode, cfg.rwMode)
			&& legal(sh[1], cfg.halfMode, cfg.rwMode)
			&& (!cfg.rwMode || sh[0] >= SH_X36 || sh[1] >= SH_X36));
		// Sleep or an illegal shape setting freezes both ports, apart from the held addresses when address latching is off
		act = !next_st.down && !next_st.cfgErr;
		// Port B runs after port A, so B wins a same-address write collision
		for (int p = 0; p < 2; p++) begin
			cas = 1'b0;
			if (cfg.fifoMode) begin
				weP[p] = (p == 0);
				goP[p] = act && rq[p].en && (p == 0 ? !st.flags.full : !st.flags.empty);
				unit   = p == 0 ? st.wrPtr[`UNIT_W-1:0] : st.rdPtr[`UNIT_W-1:0];
			end else begin
				weP[p] = rq[p].we && !(cfg.rwMode && p == 1);
				goP[p] = act && rq[p].en && !(cfg.rwMode && p == 0 && !rq[p].we);
				unit   = `UNIT_W'(rq[p].addr[`UNIT_W-1:0] << sh[p]);
				cas    = rq[p].addr[`CASCADE_BIT];
			end
			goP[p] = goP[p] && (p == 0 ? PORT_A_USED : PORT_B_USED);
			off = unit[`OFF_W-1:0];
			wi  = wordIdx(unit, cfg.halfMode, sel[p]);
			if (cfg.addrLatchOff) begin
				next_st.held[p] = rq[p].addr;
			end else if (goP[p]) begin
				next_st.held[p] = rq[p].addr;
			end
			if (goP[p] && cas) begin
				rdP[p]   = !weP[p];
				laneP[p] = casIn;
			end else if (goP[p] && weP[p]) begin
				put = putLane(rq[p].din, sh[p], off);
				if (cfg.eccEn && sh[p] == SH_X72) begin
					put[`WORD_BITS-1:0] = {eccChk, rq[p].din[`DATA_BITS-1:0]};
				end
				next_st.mem[wi] = (next_st.mem[wi] & ~put[2*`WORD_BITS-1:`WORD_BITS])
					| (put[`WORD_BITS-1:0] & put[2*`WORD_BITS-1:`WORD_BITS]);
				unique case (cfg.policy)
					READ_FIRST: begin
						rdP[p]   = 1'b1;
						laneP[p] = getLane(st.mem[wi], sh[p], off);
					end
					WRITE_FIRST: begin
						rdP[p]   = 1'b1;
						laneP[p] = getLane(next_st.mem[wi], sh[p], off);
					end
					default: begin
						rdP[p] = 1'b0;
					end
				endcase
			end else if (goP[p]) begin
				rdP[p]   = 1'b1;
				laneP[p] = getLane(st.mem[wi], sh[p], off);
				if (p == 1) begin
					next_st.sbit = cfg.eccEn && sh[p] == SH_X72 && eccS;
					next_st.dbit = cfg.eccEn && sh[p] == SH_X72 && eccD;
					if (cfg.eccEn && sh[p] == SH_X72) begin
						laneP[p] = {st.mem[wi][`WORD_BITS-1:`DATA_BITS], eccData};
					end
				end
			end
			if (goP[p] && cfg.fifoMode) begin
				if (p == 0) begin
					next_st.wrPtr = st.wrPtr + unitsOf(sh[0]);
				end else begin
					next_st.rdPtr = st.rdPtr + unitsOf(sh[1]);
				end
			end
			if (rdP[p]) next_st.stage[p] = laneP[p];
			if (act) begin
				next_st.dout[p] = cfg.outReg ? st.stage[p]
					: (rdP[p] ? laneP[p] : st.dout[p]);
			end
		end
		// Leaving queue mode empties the queue
		if (!cfg.fifoMode) begin
			next_st.wrPtr = '0;
			next_st.rdPtr = '0;
		end
		cnt = next_st.wrPtr - next_st.rdPtr;
		cap = cfg.halfMode ? `CAP_HALF : `CAP_FULL;
		next_st.flags.full      = (cap - cnt) < unitsOf(sh[0]);
		next_st.flags.empty     = cnt < unitsOf(sh[1]);
		next_st.flags.progFull  = cnt >= thr.progFullAt;
		next_st.flags.progEmpty = cnt <= thr.progEmptyAt;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st       <= '0;
			st.flags <= `FLAGS_RST;
		end else begin
			st <= next_st;
		end
	end

	assign doutA       = st.dout[0];
	assign doutB       = st.dout[1];
	assign heldAddrA   = st.held[0];
	assign heldAddrB   = st.held[1];
	assign casOut      = st.stage[1];
	assign sbitErr     = st.sbit;
	assign dbitErr     = st.dbit;
	assign extEncCheck = st.xChk;
	assign extDecData  = st.xData;
	assign extSbitErr  = st.xS;
	assign extDbitErr  = st.xD;
	assign flags       = st.flags;
	assign cfgError    = st.cfgErr;
	assign poweredDown = st.down;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	direct_read_a: assert property (
		rdP[1] && !cfg.outReg && !cfg.sleep |=> doutB == $past(laneP[1])
	) else $error("read data not on the next edge");
	pipe_read_a: assert property (
		rdP[1] && cfg.outReg ##1 cfg.outReg && !cfg.sleep && !cfgError
		|-> ##1 doutB == $past(laneP[1], 2)
	) else $error("pipelined read not two edges later");
	no_change_a: assert property (
		goP[0] && weP[0] && cfg.policy == NO_CHANGE && !cfg.outReg |=> $stable(doutA)
	) else $error("output moved during a hold-policy write");
	write_first_a: assert property (
		goP[0] && weP[0] && !cfg.fifoMode && !reqA.addr[15] && cfg.policy == WRITE_FIRST
		&& !cfg.outReg && cfg.shapeA == SH_X18 |=> doutA[15:0] == $past(reqA.din[15:0])
	) else $error("write-first output not the new data");
	held_addr_a: assert property (
		goP[0] |=> heldAddrA == $past(reqA.addr)
	) else $error("address not held after operation");
	sleep_hold_a: assert property (
		cfg.sleep |=> poweredDown && $stable(doutA) && $stable(doutB)
	) else $error("memory active while gated");
	wide_mode_a: assert property (
		!cfg.rwMode && (cfg.shapeA == SH_X72 || cfg.shapeB == SH_X72) |=> cfgError
	) else $error("wide shape accepted outside split read/write mode");

	full_stop_a: assert property (
		cfg.fifoMode && flags.full |=> !cfg.fifoMode || st.wrPtr == $past(st.wrPtr)
	) else $error("write accepted while full");

	empty_stop_a: assert property (
		cfg.fifoMode && flags.empty |=> !cfg.fifoMode || st.rdPtr == $past(st.rdPtr)
	) else $error("read accepted while empty");

	prog_full_a: assert property (
		##1 flags.progFull == ((st.wrPtr - st.rdPtr) >= $past(thr.progFullAt))
	) else $error("programmable full threshold mismatch");

	ecc_excl_a: assert property (
		rdP[1] && cfg.eccEn && cfg.shapeB == SH_X72 |=> !(sbitErr && dbitErr)
	) else $error("single and double error flagged together");

	fifo_full_c: cover property (cfg.fifoMode && flags.full);
	read_first_c: cover property (goP[0] && weP[0] && cfg.policy == READ_FIRST);
	ecc_fix_c: cover property (sbitErr);

endmodule // block_ram

// [block_ram_tb_top.sv]
// Self-checking bench for the configurable block memory
module block_ram_tb_top
	import bram_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [63:0] D = 64'h0123_4567_89AB_CDEF;
	localparam shape_t SHP[6] = '{SH_X1, SH_X2, SH_X4, SH_X9, SH_X18, SH_X36};
	localparam int WID[6] = '{1, 2, 4, 8, 16, 32};
	localparam logic [15:0] ADR[6] = '{16'h0004, 16'h0003, 16'h0001, 16'h0001, 16'h0001, 16'h0000};
	localparam logic [31:0] EXV[6] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0007,
		32'h0000_0056, 32'h0000_1234, 32'h1234_5678};

	logic        mclk, sys_rst, sbitErr, dbitErr, extSbitErr, extDbitErr, cfgError, poweredDown;
	mem_cfg_t    cfg;
	fifo_thr_t   thr;
	port_req_t   reqA, reqB;
	fifo_flags_t flags;
	logic [71:0] doutA, doutB, casIn, casOut, extDecWord;
	logic [63:0] extEncData, extDecData;
	logic [15:0] heldAddrA, heldAddrB;
	logic [7:0]  extEncCheck;
	int          err_count, tests_run, cycles;

	block_ram block_ram_i (
		.mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .thr(thr), .reqA(reqA), .reqB(reqB),
		.doutA(doutA), .doutB(doutB), .heldAddrA(heldAddrA), .heldAddrB(heldAddrB),
		.casIn(casIn), .casOut(casOut), .sbitErr(sbitErr), .dbitErr(dbitErr),
		.extEncData(extEncData), .extEncCheck(extEncCheck), .extDecWord(extDecWord),
		.extDecData(extDecData), .extSbitErr(extSbitErr), .extDbitErr(extDbitErr),
		.flags(flags), .cfgError(cfgError), .poweredDown(poweredDown)
	);
	bram_user_model bram_user_model_i (.mclk(mclk), .reqA(reqA), .reqB(reqB));

	// ********
	// Helpers
	// ********
	task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic setCfg(input mem_cfg_t c);
		@(posedge mclk);
		cfg <= c;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wr(input logic b, input logic [15:0] a, input logic [71:0] d);
		bram_user_model_i.op(b, 1'b1, a, d);
	endtask
	task automatic rd(input logic b, input logic [15:0] a);
		bram_user_model_i.op(b, 1'b0, a, '0);
	endtask
	task automatic report_and_stop();
		if (err_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// Ceiling well above the roughly 3200 cycles the sequence needs
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	// ********
	// Main sequence
	// ********
	initial begin
		mem_cfg_t c;
		logic [71:0] raw;
		{err_count, tests_run, cycles} = '0;
		{cfg, casIn, extDecWord, extEncData} = '0;
		// Thresholds off zero, so the programmable flags settle at their reset levels
		thr = '{progFullAt: 16'h4000, progEmptyAt: 16'h0040};
		sys_rst = 1'b1;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		tick(1);
		chk(72'(flags), 72'h5);
		chk(doutA, '0);
		chk(72'({cfgError, poweredDown}), 72'h0);
		c = '0;
		c.shapeA = SH_X36;
		setCfg(c);
		wr(1'b0, 16'h0000, 72'h00_0000_0000_1234_5678);
		for (int i = 0; i < 6; i++) begin
			c.shapeB = SHP[i];
			setCfg(c);
			rd(1'b1, ADR[i]);
			chk(doutB & ((72'h1 << WID[i]) - 72'h1), 72'(EXV[i]));
		end
		rd(1'b1, 16'h0123);
		tick(2);
		chk(72'(heldAddrB), 72'h0123);
		c.addrLatchOff = 1'b1;
		setCfg(c);
		tick(2);
		chk(72'(heldAddrB), 72'hFEDC);
		c = '0;
		c.halfMode = 1'b1;
		c.shapeA = SH_X18;
		c.shapeB = SH_X18;
		for (int h = 0; h < 2; h++) begin
			c.halfSelA = h[0];
			setCfg(c);
			wr(1'b0, 16'h0003, h ? 72'h2222 : 72'h1111);
		end
		for (int h = 0; h < 2; h++) begin
			c.halfSelB = h[0];
			setCfg(c);
			rd(1'b1, 16'h0003);
			chk(72'(doutB[15:0]), h ? 72'h2222 : 72'h1111);
		end
		c.shapeA = SH_X36;
		setCfg(c);
		tick(2);
		chk(72'(cfgError), 72'h1);
		c = '0;
		c.shapeA = SH_X72;
		setCfg(c);
		tick(2);
		chk(72'(cfgError), 72'h1);
		c.rwMode = 1'b1;
		setCfg(c);
		tick(2);
		chk(72'(cfgError), 72'h0);
		c = '0;
		c.shapeA = SH_X18;
		c.shapeB = SH_X18;
		for (int p = 0; p < 3; p++) begin
			c.policy = policy_t'(p);
			setCfg(c);
			wr(1'b0, 16'h0009, 72'(16'h0A00 + p));
			wr(1'b0, 16'h0002, 72'(16'h0B00 + p));
			rd(1'b0, 16'h0009);
			wr(1'b0, 16'h0002, 72'(16'h0C00 + p));
			chk(72'(doutA[15:0]), 72'(p == 0 ? 16'h0B00 + p : p == 1 ? 16'h0C00 + p : 16'h0A00 + p));
		end
		wr(1'b0, 16'h0014, 72'h5A5A);
		rd(1'b1, 16'h0015);
		c.outReg = 1'b1;
		setCfg(c);
		rd(1'b1, 16'h0014);
		chk(72'(doutB[15:0]), 72'h0);
		tick(1);
		chk(72'(doutB[15:0]), 72'h5A5A);
		c.outReg = 1'b0;
		c.sleep = 1'b1;
		setCfg(c);
		tick(2);
		chk(72'(poweredDown), 72'h1);
		wr(1'b0, 16'h0014, 72'hA5A5);
		chk(72'(heldAddrA), 72'h0014);
		c.sleep = 1'b0;
		setCfg(c);
		rd(1'b1, 16'h0014);
		chk(72'(doutB[15:0]), 72'h5A5A);
		c = '0;
		c.rwMode = 1'b1;
		c.shapeA = SH_X72;
		c.shapeB = SH_X72;
		c.eccEn = 1'b1;
		setCfg(c);
		wr(1'b0, 16'h000A, {8'h00, D});
		rd(1'b1, 16'h000A);
		chk(72'({sbitErr, dbitErr, doutB[63:0]}), 72'(D));
		c.eccEn = 1'b0;
		setCfg(c);
		rd(1'b1, 16'h000A);
		raw = doutB;
		for (int i = 0; i < 2; i++) begin
			c.eccEn = 1'b0;
			setCfg(c);
			wr(1'b0, 16'h000A, {raw[71:64], D ^ (i ? 64'h3 : 64'h1)});
			c.eccEn = 1'b1;
			setCfg(c);
			rd(1'b1, 16'h000A);
			chk(72'({sbitErr, dbitErr, doutB[63:0]}), 72'({i == 0, i == 1, D ^ (i ? 64'h3 : 64'h0)}));
		end
		@(posedge mclk) extEncData <= D;
		tick(2);
		@(posedge mclk) extDecWord <= {extEncCheck, D ^ 64'h0000_0100_0000_0000};
		tick(2);
		chk(72'({extSbitErr, extDbitErr, extDecData}), 72'({2'b10, D}));
		c.eccEn = 1'b0;
		setCfg(c);
		@(posedge mclk) casIn <= 72'hC3_0F0F_1E1E_2D2D_3C3C;
		rd(1'b1, 16'h8000);
		chk(doutB, 72'hC3_0F0F_1E1E_2D2D_3C3C);
		chk(casOut, 72'hC3_0F0F_1E1E_2D2D_3C3C);
		@(posedge mclk) thr <= '{progFullAt: 16'h4000, progEmptyAt: 16'h0040};
		c.fifoMode = 1'b1;
		setCfg(c);
		tick(1);
		chk(72'(flags), 72'h5);
		for (int i = 0; i < 513; i++) begin
			wr(1'b0, 16'h0000, {8'h00, {4{16'(i)}}});
			if (i == 0 || i == 255 || i == 511) begin
				tick(1);
				chk(72'(flags), i == 0 ? 72'h1 : i == 255 ? 72'h2 : 72'hA);
			end
		end
		for (int i = 0; i < 512; i++) begin
			rd(1'b1, 16'h0000);
			chk(72'(doutB[63:0]), 72'({4{16'(i)}}));
		end
		tick(1);
		chk(72'(flags), 72'h5);
		c = '0;
		c.shapeA = SH_X36;
		c.shapeB = SH_X9;
		c.fifoMode = 1'b1;
		setCfg(c);
		wr(1'b0, 16'h0000, 72'h1234_5678);
		for (int i = 0; i < 4; i++) begin
			rd(1'b1, 16'h0000);
			chk(72'(doutB[7:0]), 72'(8'(32'h1234_5678 >> (8 * i))));
		end
		tick(1);
		chk(72'(flags), 72'h5);
		c = '0;
		c.halfMode = 1'b1;
		c.rwMode = 1'b1;
		c.shapeA = SH_X36;
		c.fifoMode = 1'b1;
		setCfg(c);
		// A half queue is full after 512 words of 32 bits
		for (int i = 0; i < 512; i++) begin
			wr(1'b0, 16'h0000, 72'(i));
		end
		tick(1);
		chk(72'(flags), 72'hA);
		report_and_stop();
	end
endmodule // block_ram_tb_top

// [bram_map.svh]
// Offsets, sizes, reset values and counts of the configurable block memory
`ifndef BRAM_MAP_SVH
`define BRAM_MAP_SVH
// Overview of operation
// - One 36 Kb array, two independent ports sharing only the stored data; here both also share mclk, the write policy and the output register.
// - The array works whole or as two independent 18 Kb halves.
// - Every read and write happens on the clock edge, never asynchronously.
// - Data, address, clock enables and write enables are captured on the edge.
// - Address is held after each operation unless address latching is off.
// - Optional output register adds exactly one cycle of read latency.
// - During a write the output shows old data, new data, or holds.
// - A power gating input, and unused instances, put the memory to sleep.
// - Full array port shapes run from 32K x 1 to 512 x 72.
// - Each port picks its shape freely, for memory and queue use.
// - A half supports 16K x 1 to 512 x 36 with every other option; array error correction needs 512 x 72, which a half rejects.
// - Widths above 18 (half) or 36 (full) need split read/write mode.
// - In split read/write mode one side is 32/36 or 64/72 wide.
// - 64-bit words carry eight Hamming bits: singles corrected, doubles flagged.
// - The encoder and decoder also serve external 64 to 72 bit memories.
// - The array also works as a 36 Kb or 18 Kb queue.
// - Queue controller steps its own addresses and raises four occupancy flags.
// - Queue read and write widths may differ.
// - A cascade path joins neighbouring memories into larger arrays.

// ****************************************
// Array geometry
// ****************************************
`define WORD_BITS   72
`define DATA_BITS   64
`define CHK_BITS    8
`define WORDS       512
`define WIDX_W      9
`define UNIT_W      15
`define OFF_W       6
`define ADDR_W      16
`define CASCADE_BIT 15

// ****************************************
// Queue counts and reset values
// ****************************************
`define PTR_W       16
`define CAP_FULL    16'h8000
`define CAP_HALF    16'h4000
`define FLAGS_RST   4'h5

`endif

// [bram_pkg.sv]
// Types shared by the block memory and its error-correction codec
package bram_pkg;

	typedef enum logic [2:0] {
		SH_X1  = 3'h0,
		SH_X2  = 3'h1,
		SH_X4  = 3'h2,
		SH_X9  = 3'h3,
		SH_X18 = 3'h4,
		SH_X36 = 3'h5,
		SH_X72 = 3'h6
	} shape_t;

	typedef enum logic [1:0] {
		READ_FIRST  = 2'h0,
		WRITE_FIRST = 2'h1,
		NO_CHANGE   = 2'h2
	} policy_t;

	typedef struct packed {
		logic        en;
		logic        we;
		logic [15:0] addr;
		logic [71:0] din;
	} port_req_t;

	typedef struct packed {
		shape_t  shapeA;
		shape_t  shapeB;
		logic    halfMode;
		logic    halfSelA;
		logic    halfSelB;
		logic    rwMode;
		logic    outReg;
		policy_t policy;
		logic    addrLatchOff;
		logic    eccEn;
		logic    fifoMode;
		logic    sleep;
	} mem_cfg_t;

	typedef struct packed {
		logic [15:0] progFullAt;
		logic [15:0] progEmptyAt;
	} fifo_thr_t;

	typedef struct packed {
		logic full;
		logic empty;
		logic progFull;
		logic progEmpty;
	} fifo_flags_t;

endpackage

// [bram_user_model.sv]
// User fabric model that drives both ports of the block memory
module bram_user_model
	import bram_pkg::*;
(
	// Clock
	input  wire logic mclk,
	// Port requests
	output port_req_t reqA,
	output port_req_t reqB
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reqA = '0;
		reqB = '0;
	end

	// ********
	// One access, held for exactly the edge that takes it
	// ********
	task automatic op(input logic portB, input logic we, input logic [15:0] addr,
			input logic [71:0] din);
		port_req_t r;
		port_req_t idle;
		r = '{en: 1'b1, we: we, addr: addr, din: din};
		// Released lines show the inverse, so a stale value never looks held
		idle = '{en: 1'b0, we: 1'b0, addr: ~addr, din: ~din};
		@(posedge mclk);
		// Only one port moves per access, so the ports never write one address together
		if (portB) begin
			reqB <= r;
		end else begin
			reqA <= r;
		end
		@(posedge mclk);
		if (portB) begin
			reqB <= idle;
		end else begin
			reqA <= idle;
		end
		#1;
	endtask
endmodule // bram_user_model

// [secded_codec.sv]
// Hamming SEC-DED encoder and decoder for 64 data bits and 8 check bits
`include "bram_map.svh"

module secded_codec
	import bram_pkg::*;
(
	// Encoder
	input  wire logic [`DATA_BITS-1:0] encData,
	output logic      [`CHK_BITS-1:0]  encCheck,
	// Decoder
	input  wire logic [`WORD_BITS-1:0] decWord,
	output logic      [`DATA_BITS-1:0] decData,
	output logic                       sbitErr,
	output logic                       dbitErr
);

	// ****************************************
	// Code word helpers
	// ****************************************
	// Data fills the positions of the code word that are not powers of two
	function automatic logic [`WORD_BITS-1:0] spread(input logic [`DATA_BITS-1:0] d);
		logic [`WORD_BITS-1:0] cw;
		int k;
		cw = '0;
		k = 0;
		for (int p = 1; p < `WORD_BITS; p++) begin
			if ((p & (p - 1)) != 0) begin
				cw[p] = d[k];
				k++;
			end
		end
		return cw;
	endfunction

	function automatic logic [`DATA_BITS-1:0] gather(input logic [`WORD_BITS-1:0] cw);
		logic [`DATA_BITS-1:0] d;
		int k;
		d = '0;
		k = 0;
		for (int p = 1; p < `WORD_BITS; p++) begin
			if ((p & (p - 1)) != 0) begin
				d[k] = cw[p];
				k++;
			end
		end
		return d;
	endfunction

	function automatic logic [6:0] syndrome(input logic [`WORD_BITS-1:0] cw);
		logic [6:0] s;
		s = '0;
		for (int p = 1; p < `WORD_BITS; p++) begin
			for (int i = 0; i < 7; i++) begin
				if (p[i]) s[i] = s[i] ^ cw[p];
			end
		end
		return s;
	endfunction

	// ****************************************
	// Encode and decode
	// ****************************************
	logic [6:0] encSyn;

	assign encSyn   = syndrome(spread(encData));
	assign encCheck = {^encData ^ ^encSyn, encSyn};

	always_comb begin
		logic [`WORD_BITS-1:0] cw;
		logic [6:0]            s;
		logic                  ov;
		cw = spread(decWord[`DATA_BITS-1:0]);
		for (int i = 0; i < 7; i++) cw[1 << i] = decWord[`DATA_BITS + i];
		s  = syndrome(cw);
		ov = ^decWord;
		// An odd overall parity with an in-range syndrome is one flipped bit
		sbitErr = ov && s < 7'h48;
		dbitErr = (!ov && s != 7'h0) || (ov && s >= 7'h48);
		if (sbitErr && s != 7'h0) cw[s] = !cw[s];
		decData = gather(cw);
	end

endmodule // secded_codec
